/* bench/sepp_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sepp_chk #(
  parameter int WR_CYCLES = 64
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic wp_i,
  input wire logic [2:0] unused_select_pins_i,
  input wire logic write_busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  int busy_cnt;
  int stop_age;
  // Saturates so an idle bus never wraps the age
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cnt <= 0;
      stop_age <= 99;
    end else begin
      busy_cnt <= write_busy_o ? busy_cnt + 1 : 0;
      stop_age <= ($rose(sda_i) && scl_i) ? 0 : (stop_age < 99 ? stop_age + 1 : 99);
    end
  end
  a_drive_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  a_busy_quiet: assert property (write_busy_o |-> !sda_oe_o)
    else $error("ack while busy");
  a_busy_len: assert property ($fell(write_busy_o) |-> busy_cnt == WR_CYCLES)
    else $error("write cycle length wrong");
  a_busy_hold: assert property ($rose(write_busy_o) |=> write_busy_o [*8])
    else $error("write cycle cut short");
  a_busy_stop: assert property ($rose(write_busy_o) |-> stop_age <= 8)
    else $error("write cycle without stop");
  a_wp_no_busy: assert property ($rose(write_busy_o) |-> !$past(wp_i, 6))
    else $error("programming while inhibited");
  a_oe_rise_low: assert property ($rose(sda_oe_o) |-> !$past(scl_i))
    else $error("drive began with clock high");
  a_stop_release: assert property ($rose(sda_i) && scl_i |=> !sda_oe_o [*4])
    else $error("line held after stop");
  cover property ($rose(write_busy_o));
  cover property ($fell(write_busy_o));
  cover property ($rose(sda_oe_o));
endmodule // sepp_chk
bind sepp_top sepp_chk #(.WR_CYCLES(WR_CYCLES)) chk_u (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .wp_i(wp_i), .unused_select_pins_i(unused_select_pins_i), .write_busy_o(write_busy_o));
`default_nettype wire

/* bench/sepp_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sepp_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic sta();
    w(1);
    sda_low_o = 1'b0;
    w(3);
    scl_o = 1'b1;
    w(4);
    sda_low_o = 1'b1;
    w(4);
    scl_o = 1'b0;
  endtask
  task automatic sto();
    w(1);
    sda_low_o = 1'b1;
    w(3);
    scl_o = 1'b1;
    w(4);
    sda_low_o = 1'b0;
    w(4);
  endtask
  // data only moves with clock low
  task automatic bit_io(input logic b, output logic s);
    w(1);
    sda_low_o = !b;
    w(3);
    scl_o = 1'b1;
    w(4);
    s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic tx(input logic [7:0] b, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(b[i], ak);
    bit_io(1'b1, ak);
  endtask
  task automatic rx(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!ack, s);
  endtask
endmodule // sepp_master
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int WRC = 160;
  logic clk;
  logic rst_b;
  logic wp;
  logic [2:0] sel;
  logic scl;
  logic m_low;
  logic sda_o;
  logic oe;
  logic busy;
  logic a;
  logic [7:0] d;
  wire logic sda;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  // Pull-up wins unless a party pulls low
  assign sda = !(m_low || oe);
  sepp_top #(.WR_CYCLES(WRC)) dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(oe), .wp_i(wp), .unused_select_pins_i(sel),
    .write_busy_o(busy));
  sepp_master m_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Ceiling is about five times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] cw, input logic [7:0] ad, input logic [31:0] dd);
    m_u.sta();
    m_u.tx(cw, a);
    chk("ctrl ack", 8'h00, {7'h00, a});
    m_u.tx(ad, a);
    for (int i = 3; i >= 0; i--) m_u.tx(dd[8*i+:8], a);
    chk("data ack", 8'h00, {7'h00, a});
    m_u.sto();
  endtask
  task automatic seta(input logic [7:0] ad);
    m_u.tx(ad, a);
    m_u.sta();
    m_u.tx(8'ha3, a);
    chk("read ack", 8'h00, {7'h00, a});
  endtask
  task automatic rd1(input logic [7:0] ad, input logic [7:0] e);
    m_u.sta();
    m_u.tx(8'ha2, a);
    seta(ad);
    m_u.rx(1'b0, d);
    chk("rand byte", e, d);
    m_u.sto();
  endtask
  task automatic t_write();
    sel = 3'h5;
    wr(8'ha2, 8'h1e, 32'h11223344);
    chk("busy", 8'h01, {7'h00, busy});
    m_u.sta();
    m_u.tx(8'ha2, a);
    chk("poll busy", 8'h01, {7'h00, a});
    m_u.sto();
    repeat (400) if (busy) @(posedge clk);
    #1;
    chk("busy end", 8'h00, {7'h00, busy});
    m_u.sta();
    m_u.tx(8'ha2, a);
    chk("poll done", 8'h00, {7'h00, a});
    seta(8'h1e);
    m_u.rx(1'b1, d);
    chk("seq 0", 8'h11, d);
    m_u.rx(1'b0, d);
    chk("seq 1", 8'h22, d);
    m_u.sto();
    $display("test write and read done");
  endtask
  task automatic t_pointer();
    sel = 3'h2;
    rd1(8'h10, 8'h33);
    chk("no program", 8'h00, {7'h00, busy});
    m_u.sta();
    m_u.tx(8'ha3, a);
    m_u.rx(1'b0, d);
    chk("current", 8'h44, d);
    m_u.sto();
    $display("test pointer done");
  endtask
  task automatic t_protect();
    wp = 1'b1;
    wr(8'ha2, 8'h10, 32'h55555555);
    repeat (10) @(posedge clk);
    #1;
    chk("wp busy", 8'h00, {7'h00, busy});
    rd1(8'h10, 8'h33);
    wp = 1'b0;
    m_u.sta();
    m_u.tx(8'hb3, a);
    chk("bad code", 8'h01, {7'h00, a});
    m_u.sto();
    $display("test protect done");
  endtask
  task automatic t_wrap();
    wr(8'ha6, 8'hfc, 32'h0a0b0c0d);
    repeat (200) @(posedge clk);
    #1;
    wr(8'ha0, 8'h00, 32'h5a6b7c8d);
    repeat (200) @(posedge clk);
    #1;
    m_u.sta();
    repeat (3) m_u.bit_io(1'b1, a);
    m_u.sta();
    m_u.tx(8'ha6, a);
    chk("abort ack", 8'h00, {7'h00, a});
    m_u.tx(8'hff, a);
    m_u.sta();
    m_u.tx(8'ha7, a);
    chk("blk read ack", 8'h00, {7'h00, a});
    m_u.rx(1'b1, d);
    chk("top byte", 8'h0d, d);
    m_u.rx(1'b0, d);
    chk("wrapped", 8'h5a, d);
    m_u.sto();
    $display("test wrap done");
  endtask
  initial begin
    rst_b = 1'b0;
    wp = 1'b0;
    sel = 3'h0;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    t_write();
    t_pointer();
    t_protect();
    t_wrap();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

/* rtl/sepp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sepp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sepp_fifo_s;

  sepp_fifo_s f_r;
  sepp_fifo_s f_nxt;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic push;
  logic pop;

  assign in_ready_o = (f_r.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (f_r.cnt != '0);
  assign out_data_o = mem[f_r.rp];
  assign push = in_valid_i & in_ready_o & ~flush_i;
  assign pop = out_valid_o & out_ready_i & ~flush_i;

  always_comb begin
    f_nxt = f_r;
    if (flush_i) begin
      f_nxt = '0;
    end else begin
      if (push) begin
        f_nxt.wp = f_r.wp + 1'b1;
      end
      if (pop) begin
        f_nxt.rp = f_r.rp + 1'b1;
      end
      f_nxt.cnt = f_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // Storage needs no reset
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[f_r.wp] <= in_data_i;
    end
  end

endmodule // sepp_fifo
`default_nettype wire

/* rtl/sepp_pkg.sv */
package sepp_pkg;

  // Memory geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int MEM_WORDS = 1024;
  localparam int PAGE_DEPTH = 16;
  localparam int ENTRY_W = ADDR_W + DATA_W;

  // Control byte layout
  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam int CTRL_CODE_LSB = 4;
  localparam int BLK_MSB = 2;
  localparam int BLK_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BITS = 4;

  // Self-timed write cycle
  localparam int CLK_PERIOD_NS = 20;
  localparam int TWR_MS = 10;
  localparam int TWR_CYCLES = TWR_MS * 1000000 / CLK_PERIOD_NS;
  localparam int WCNT_W = 20;

  // Reset values
  localparam logic [ADDR_W-1:0] PTR_RST = 10'h000;
  localparam logic [3:0] BITCNT_RST = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CTRL,
    ST_CTRL_ACK,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } sepp_state_e;

endpackage

/* rtl/sepp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sepp_top
  import sepp_pkg::*;
#(
  parameter int WR_CYCLES = TWR_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic wp_i,
  input wire logic [2:0] unused_select_pins_i,
  output logic write_busy_o
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic wp_m;
    logic wp_s;
    sepp_state_e st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [ADDR_W-1:0] ptr;
    logic oe;
    logic pin_lvl;
    logic got_data;
    logic busy;
    logic [WCNT_W-1:0] wcnt;
    logic push_v;
    logic [ENTRY_W-1:0] push_d;
  } sepp_state_s;

  sepp_state_s s_r;
  sepp_state_s s_nxt;

  logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
  logic [DATA_W-1:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ENTRY_W-1:0] fifo_out_data;
  logic fifo_flush;
  logic in_write;
  logic scl_high;
  logic byte_done;
  logic rd_first;
  logic wr_done;
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;

  // Page pointer step keeps upper bits fixed
  function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] p);
    page_inc = {p[ADDR_W-1:PAGE_BITS], p[PAGE_BITS-1:0] + 4'h1};
  endfunction

  // Open-drain drive: low for a zero bit, released for a one
  function automatic logic pull_for(input logic bit_v);
    pull_for = ~bit_v;
  endfunction

  // Control code match, refused outright while programming
  function automatic logic ctrl_hit(input logic [7:0] c, input logic busy_v);
    ctrl_hit = (c[7:CTRL_CODE_LSB] == CTRL_CODE) && !busy_v;
  endfunction

  // Block bits sit just above the read/write bit
  function automatic logic [ADDR_W-9:0] blk_of(input logic [7:0] c);
    blk_of = c[BLK_MSB:BLK_LSB];
  endfunction

  assign rd_byte = mem[s_r.ptr];
  // Bit that leads a freshly fetched byte onto the line
  assign rd_first = pull_for(rd_byte[DATA_W-1]);
  // edges of clock and data decide bus conditions
  assign scl_rise = s_r.scl_s & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_s & s_r.scl_d;
  // Both samples high, so a data edge is never mistaken near a clock edge
  assign scl_high = s_r.scl_s & s_r.scl_d;
  assign start_cond = scl_high & s_r.sda_d & ~s_r.sda_s;
  assign stop_cond = scl_high & ~s_r.sda_d & s_r.sda_s;
  assign in_write = (s_r.st == ST_WDATA) || (s_r.st == ST_WDATA_ACK);
  // Ninth clock begins on the fall after the eighth bit
  assign byte_done = scl_fall && (s_r.bitcnt == 4'(BYTE_BITS));
  // Last cycle of the self-timed write
  assign wr_done = s_r.busy && (s_r.wcnt == WCNT_W'(WR_CYCLES - 1));

  always_comb begin
    s_nxt = s_r;
    fifo_flush = 1'b0;
    // Two-stage synchronisers for the clock, data and inhibit pins
    s_nxt.scl_m = scl_i;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_d = s_r.scl_s;
    s_nxt.sda_m = sda_i;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_d = s_r.sda_s;
    s_nxt.wp_m = wp_i;
    s_nxt.wp_s = s_r.wp_m;
    // line level held low, only enable toggles
    s_nxt.pin_lvl = 1'b0;

    // Pending page entry leaves once the buffer takes it
    if (s_r.push_v && fifo_in_ready) begin
      s_nxt.push_v = 1'b0;
    end

    // Self-timed write cycle
    if (s_r.busy) begin
      if (wr_done) begin
        s_nxt.busy = 1'b0;
        s_nxt.wcnt = '0;
      end else begin
        s_nxt.wcnt = s_r.wcnt + 1'b1;
      end
    end

    if (start_cond) begin
      // start aborts any byte in flight
      // pending page data is dropped, pointer kept
      s_nxt.st = ST_CTRL;
      s_nxt.bitcnt = BITCNT_RST;
      s_nxt.oe = 1'b0;
      s_nxt.got_data = 1'b0;
      s_nxt.push_v = 1'b0;
      // Flush held off while the array still drains the buffer
      fifo_flush = ~s_r.busy;
    end else if (stop_cond) begin
      s_nxt.st = ST_IDLE;
      s_nxt.oe = 1'b0;
      s_nxt.got_data = 1'b0;
      if (in_write && s_r.got_data) begin
        // Inhibit looked at once, when the stop arrives
        if (s_r.wp_s) begin
          fifo_flush = 1'b1;
          s_nxt.push_v = 1'b0;
        end else begin
          // write cycle begins on this stop
          s_nxt.busy = 1'b1;
          s_nxt.wcnt = '0;
        end
      end
    end else begin
      case (s_r.st)
        ST_CTRL, ST_ADDR, ST_WDATA: begin
          if (scl_rise && s_r.bitcnt < 4'(BYTE_BITS)) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda_s};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end else if (byte_done) begin
            s_nxt.bitcnt = BITCNT_RST;
            if (s_r.st == ST_CTRL) begin
              // only the matching control code is answered
              if (ctrl_hit(s_r.sh, s_r.busy)) begin
                // block bits form the upper address
                s_nxt.ptr[ADDR_W-1:ADDR_W-2] = blk_of(s_r.sh);
                s_nxt.oe = 1'b1;
                s_nxt.st = ST_CTRL_ACK;
              end else begin
                s_nxt.st = ST_IGNORE;
              end
            end else if (s_r.st == ST_ADDR) begin
              s_nxt.ptr[7:0] = s_r.sh;
              s_nxt.oe = 1'b1;
              s_nxt.st = ST_ADDR_ACK;
            end else begin
              s_nxt.push_v = 1'b1;
              s_nxt.push_d = {s_r.ptr, s_r.sh};
              s_nxt.got_data = 1'b1;
              s_nxt.ptr = page_inc(s_r.ptr);
              s_nxt.oe = 1'b1;
              s_nxt.st = ST_WDATA_ACK;
            end
          end
        end
        ST_CTRL_ACK: begin
          if (scl_fall) begin
            s_nxt.bitcnt = BITCNT_RST;
            if (s_r.sh[RW_BIT]) begin
              // first data bit goes out after the acknowledge
              // current read uses the held pointer with the new block bits on top
              s_nxt.sh = rd_byte;
              s_nxt.oe = rd_first;
              s_nxt.st = ST_RDATA;
            end else begin
              s_nxt.oe = 1'b0;
              s_nxt.st = ST_ADDR;
            end
          end
        end
        ST_ADDR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            s_nxt.oe = 1'b0;
            s_nxt.bitcnt = BITCNT_RST;
            s_nxt.st = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            s_nxt.sh = {s_r.sh[6:0], 1'b1};
          end else if (scl_fall) begin
            if (s_r.bitcnt == 4'(BYTE_BITS)) begin
              s_nxt.ptr = s_r.ptr + 1'b1;
              s_nxt.oe = 1'b0;
              s_nxt.st = ST_RACK;
            end else begin
              s_nxt.oe = pull_for(s_r.sh[7]);
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && s_r.sda_s) begin
            s_nxt.st = ST_IGNORE;
          end else if (scl_fall) begin
            s_nxt.sh = rd_byte;
            s_nxt.oe = rd_first;
            s_nxt.bitcnt = BITCNT_RST;
            s_nxt.st = ST_RDATA;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          s_nxt.oe = 1'b0;
        end
        default: begin
          s_nxt.oe = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  // Drain during the write cycle; when full before stop, oldest entry is
  // dropped so only the last page-worth survives
  assign fifo_out_ready = s_r.busy | (s_r.push_v & ~fifo_in_ready);

  sepp_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(PAGE_DEPTH)
  ) u_page_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .flush_i(fifo_flush),
    .in_valid_i(s_r.push_v),
    .in_ready_o(fifo_in_ready),
    .in_data_i(s_r.push_d),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.scl_m <= 1'b1;
      s_r.scl_s <= 1'b1;
      s_r.scl_d <= 1'b1;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.st <= ST_IDLE;
      s_r.ptr <= PTR_RST;
      s_r.bitcnt <= BITCNT_RST;
      // Line released and no write pending out of reset
      s_r.oe <= 1'b0;
      s_r.pin_lvl <= 1'b0;
      s_r.busy <= 1'b0;
      s_r.wcnt <= '0;
      s_r.push_v <= 1'b0;
      s_r.got_data <= 1'b0;
      s_r.wp_m <= 1'b0;
      s_r.wp_s <= 1'b0;
      s_r.sh <= '0;
      s_r.push_d <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array programmed only inside the write cycle
  // Inhibited pages are flushed from the buffer at the stop, never programmed
  assign mem_we = s_r.busy & fifo_out_valid;
  assign mem_wa = fifo_out_data[ENTRY_W-1:DATA_W];
  assign mem_wd = fifo_out_data[DATA_W-1:0];

  always_ff @(posedge core_clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign sda_o = s_r.pin_lvl;
  assign sda_oe_o = s_r.oe;
  assign write_busy_o = s_r.busy;
  // select pins have no load inside the block
  logic unused_sel;
  assign unused_sel = ^unused_select_pins_i;

endmodule // sepp_top
`default_nettype wire
